//--- hdl/cmcm_pkg.sv
// Constants, types and register map for the cache and machine-check block
package cmcm_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 64;

  // Register offsets, as seen on the register port
  localparam logic [11:0] OFF_CACHE_CTL = 12'h11e;
  localparam logic [11:0] OFF_FAST_CS = 12'h174;
  localparam logic [11:0] OFF_FAST_SP = 12'h175;
  localparam logic [11:0] OFF_FAST_IP = 12'h176;
  localparam logic [11:0] OFF_MC_CAP = 12'h179;
  localparam logic [11:0] OFF_MC_STATUS = 12'h17a;
  localparam logic [11:0] OFF_PERF_SEL0 = 12'h186;
  localparam logic [11:0] OFF_PERF_SEL1 = 12'h187;
  localparam logic [11:0] OFF_PERF_STATUS = 12'h198;
  localparam logic [11:0] OFF_PERF_CTL = 12'h199;
  localparam logic [11:0] OFF_CLK_MOD = 12'h19a;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h1f0;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h1f1;

  // Cache control fields
  localparam int CC_HW_EN_BIT = 0;
  localparam int CC_INIT_BIT = 8;
  localparam int CC_ABSENT_BIT = 23;
  localparam logic CC_INIT_RST = 1'h0;

  // Machine-check status fields
  localparam int MC_RESTART_BIT = 0;
  localparam int MC_ERRPTR_BIT = 1;
  localparam int MC_INPROG_BIT = 2;

  // Interrupt event bits
  localparam int IRQ_W = 4;
  localparam int EV_MC_DELIVERED = 0;
  localparam int EV_SHUTDOWN = 1;
  localparam int EV_FLUSH_TAKEN = 2;
  localparam int EV_FLUSH_IGNORED = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RST = 4'h0;

  // Storage slots for the plain read-write neighbour registers
  localparam int SLOT_W = 3;
  localparam int SLOT_DEPTH = 8;
  localparam logic [2:0] SLOT_FAST_CS = 3'h0;
  localparam logic [2:0] SLOT_FAST_SP = 3'h1;
  localparam logic [2:0] SLOT_FAST_IP = 3'h2;
  localparam logic [2:0] SLOT_PERF_SEL0 = 3'h3;
  localparam logic [2:0] SLOT_PERF_SEL1 = 3'h4;
  localparam logic [2:0] SLOT_PERF_CTL = 3'h5;
  localparam logic [2:0] SLOT_CLK_MOD = 3'h6;

  localparam logic [63:0] WORD_ZERO = 64'h0;
  localparam logic FLUSH_PIN_IDLE = 1'h1;

  typedef enum logic [2:0] {
    MC_IDLE = 3'b001,
    MC_ACTIVE = 3'b010,
    MC_SHUTDOWN = 3'b100
  } cmcm_mc_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [63:0] wdata;
  } cmcm_bus_req_t;

  typedef struct packed {
    logic detect;
    logic restart_ok;
    logic error_assoc;
  } cmcm_mc_event_t;

endpackage

//--- hdl/cmcm_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module cmcm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // The first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end
    else if (ce)
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

//--- hdl/cmcm_regmem.sv
// Small word store with registered read data
`timescale 1ns/1ps
module cmcm_regmem #(
  parameter int W = 64,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
      rd_data <= '0;
    end
    else if (ce)
    begin
      if (wr_en)
      begin
        mem[wr_addr] <= wr_data;
      end
      // Read sees the old word on a same-address write
      if (rd_en)
      begin
        rd_data <= mem[rd_addr];
      end
    end
  end

endmodule

//--- hdl/cmcm_top.sv
// Cache control and machine-check status register slice
`timescale 1ns/1ps
module cmcm_top #(
  parameter logic [63:0] MC_CAP_VALUE = 64'h0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire cmcm_pkg::cmcm_bus_req_t bus_req,
  output logic [63:0] rd_data,
  input wire logic second_level_cache_hw_enabled,
  input wire logic second_level_cache_absent,
  input wire logic flush_n,
  input wire logic writeback_invalidate_request,
  input wire cmcm_pkg::cmcm_mc_event_t mc_event,
  input wire logic [63:0] performance_state_status,
  output logic cache_flush_start,
  output logic machine_check_exception,
  output logic shutdown,
  output logic irq
);

  // Address decode
  logic hit_cache_ctl;
  logic hit_mc_status;
  logic hit_mc_cap;
  logic hit_perf_status;
  logic hit_irq_status;
  logic hit_irq_mask;
  logic hit_slot;
  logic [2:0] slot_idx;

  assign hit_cache_ctl = bus_req.addr == cmcm_pkg::OFF_CACHE_CTL;
  assign hit_mc_status = bus_req.addr == cmcm_pkg::OFF_MC_STATUS;
  assign hit_mc_cap = bus_req.addr == cmcm_pkg::OFF_MC_CAP;
  assign hit_perf_status = bus_req.addr == cmcm_pkg::OFF_PERF_STATUS;
  assign hit_irq_status = bus_req.addr == cmcm_pkg::OFF_IRQ_STATUS;
  assign hit_irq_mask = bus_req.addr == cmcm_pkg::OFF_IRQ_MASK;

  assign hit_slot = (bus_req.addr == cmcm_pkg::OFF_FAST_CS)
                 || (bus_req.addr == cmcm_pkg::OFF_FAST_SP)
                 || (bus_req.addr == cmcm_pkg::OFF_FAST_IP)
                 || (bus_req.addr == cmcm_pkg::OFF_PERF_SEL0)
                 || (bus_req.addr == cmcm_pkg::OFF_PERF_SEL1)
                 || (bus_req.addr == cmcm_pkg::OFF_PERF_CTL)
                 || (bus_req.addr == cmcm_pkg::OFF_CLK_MOD);

  assign slot_idx =
    (bus_req.addr == cmcm_pkg::OFF_FAST_CS) ? cmcm_pkg::SLOT_FAST_CS :
    (bus_req.addr == cmcm_pkg::OFF_FAST_SP) ? cmcm_pkg::SLOT_FAST_SP :
    (bus_req.addr == cmcm_pkg::OFF_FAST_IP) ? cmcm_pkg::SLOT_FAST_IP :
    (bus_req.addr == cmcm_pkg::OFF_PERF_SEL0) ? cmcm_pkg::SLOT_PERF_SEL0 :
    (bus_req.addr == cmcm_pkg::OFF_PERF_SEL1) ? cmcm_pkg::SLOT_PERF_SEL1 :
    (bus_req.addr == cmcm_pkg::OFF_PERF_CTL) ? cmcm_pkg::SLOT_PERF_CTL :
    cmcm_pkg::SLOT_CLK_MOD;

  logic wr_cache_ctl;
  logic wr_mc_status;
  logic wr_irq_status;
  logic wr_irq_mask;

  assign wr_cache_ctl = bus_req.wr && hit_cache_ctl;
  assign wr_mc_status = bus_req.wr && hit_mc_status;
  assign wr_irq_status = bus_req.wr && hit_irq_status;
  assign wr_irq_mask = bus_req.wr && hit_irq_mask;

  // Plain read-write neighbours live in the word store
  logic [63:0] slot_rd_data;

  cmcm_regmem #(
    .W(cmcm_pkg::DATA_W),
    .DEPTH(cmcm_pkg::SLOT_DEPTH),
    .AW(cmcm_pkg::SLOT_W)
  ) u_slots (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .wr_en(bus_req.wr && hit_slot),
    .wr_addr(slot_idx),
    .wr_data(bus_req.wdata),
    .rd_en(bus_req.rd && hit_slot),
    .rd_addr(slot_idx),
    .rd_data(slot_rd_data)
  );

  // Cache initialised flag
  logic cache_init;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cache_init <= cmcm_pkg::CC_INIT_RST;
    end
    else if (ce && wr_cache_ctl)
    begin
      cache_init <= bus_req.wdata[cmcm_pkg::CC_INIT_BIT];
    end
  end

  // Flush pin: synchronised, then falling edge marks an assertion
  logic flush_n_sync;
  logic flush_n_prev;
  logic flush_pin_assert;

  cmcm_sync #(
    .W(1),
    .RST_VAL(cmcm_pkg::FLUSH_PIN_IDLE)
  ) u_flush_sync (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .d(flush_n),
    .q(flush_n_sync)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flush_n_prev <= cmcm_pkg::FLUSH_PIN_IDLE;
    end
    else if (ce)
    begin
      flush_n_prev <= flush_n_sync;
    end
  end

  assign flush_pin_assert = flush_n_prev && !flush_n_sync;

  // A pin assertion and an instruction request in one cycle make one flush
  logic flush_any;
  logic flush_taken;
  logic flush_ignored;

  assign flush_any = flush_pin_assert || writeback_invalidate_request;
  assign flush_taken = flush_any && cache_init;
  assign flush_ignored = flush_any && !cache_init;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cache_flush_start <= 1'h0;
    end
    else if (ce)
    begin
      cache_flush_start <= flush_taken;
    end
  end

  // Machine-check state
  cmcm_pkg::cmcm_mc_state_t mc_state;
  cmcm_pkg::cmcm_mc_state_t next_mc_state;
  logic restart_pointer_valid;
  logic next_restart_pointer_valid;
  logic error_pointer_valid;
  logic next_error_pointer_valid;
  logic machine_check_in_progress;
  logic mc_deliver;
  logic mc_to_shutdown;
  logic sw_inprog;

  assign sw_inprog = bus_req.wdata[cmcm_pkg::MC_INPROG_BIT];
  assign machine_check_in_progress = mc_state != cmcm_pkg::MC_IDLE;

  always_comb
  begin
    next_mc_state = mc_state;
    next_restart_pointer_valid = restart_pointer_valid;
    next_error_pointer_valid = error_pointer_valid;
    mc_deliver = 1'h0;
    mc_to_shutdown = 1'h0;
    // Software may rewrite the pointer flags outside MC_SHUTDOWN; a new machine check in MC_IDLE wins
    if (wr_mc_status && (mc_state != cmcm_pkg::MC_SHUTDOWN))
    begin
      next_restart_pointer_valid =
        bus_req.wdata[cmcm_pkg::MC_RESTART_BIT];
      next_error_pointer_valid = bus_req.wdata[cmcm_pkg::MC_ERRPTR_BIT];
    end
    case (mc_state)
      cmcm_pkg::MC_IDLE:
      begin
        if (mc_event.detect)
        begin
          next_mc_state = cmcm_pkg::MC_ACTIVE;
          next_restart_pointer_valid = mc_event.restart_ok;
          next_error_pointer_valid = mc_event.error_assoc;
          mc_deliver = 1'h1;
        end
        else if (wr_mc_status && sw_inprog)
        begin
          next_mc_state = cmcm_pkg::MC_ACTIVE;
        end
      end
      cmcm_pkg::MC_ACTIVE:
      begin
        // Judged on the bit as it stands, so a clear in the same cycle
        // does not rescue a second machine check
        if (mc_event.detect)
        begin
          next_mc_state = cmcm_pkg::MC_SHUTDOWN;
          mc_to_shutdown = 1'h1;
        end
        else if (wr_mc_status && !sw_inprog)
        begin
          next_mc_state = cmcm_pkg::MC_IDLE;
        end
      end
      cmcm_pkg::MC_SHUTDOWN:
      begin
        // Only reset leaves shutdown
        next_mc_state = cmcm_pkg::MC_SHUTDOWN;
      end
      default:
      begin
        next_mc_state = cmcm_pkg::MC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mc_state <= cmcm_pkg::MC_IDLE;
      restart_pointer_valid <= 1'h0;
      error_pointer_valid <= 1'h0;
    end
    else if (ce)
    begin
      mc_state <= next_mc_state;
      restart_pointer_valid <= next_restart_pointer_valid;
      error_pointer_valid <= next_error_pointer_valid;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      machine_check_exception <= 1'h0;
    end
    else if (ce)
    begin
      machine_check_exception <= mc_deliver;
    end
  end

  assign shutdown = mc_state == cmcm_pkg::MC_SHUTDOWN;

  // Interrupt status, write one to clear; a new event beats the clear
  logic [cmcm_pkg::IRQ_W-1:0] irq_status;
  logic [cmcm_pkg::IRQ_W-1:0] next_irq_status;
  logic [cmcm_pkg::IRQ_W-1:0] irq_mask;
  logic [cmcm_pkg::IRQ_W-1:0] irq_events;
  logic [cmcm_pkg::IRQ_W-1:0] irq_clear;

  always_comb
  begin
    irq_events = '0;
    irq_events[cmcm_pkg::EV_MC_DELIVERED] = mc_deliver;
    irq_events[cmcm_pkg::EV_SHUTDOWN] = mc_to_shutdown;
    irq_events[cmcm_pkg::EV_FLUSH_TAKEN] = flush_taken;
    irq_events[cmcm_pkg::EV_FLUSH_IGNORED] = flush_ignored;
  end

  assign irq_clear = wr_irq_status ?
    bus_req.wdata[cmcm_pkg::IRQ_W-1:0] : '0;
  assign next_irq_status = (irq_status & ~irq_clear) | irq_events;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_status <= cmcm_pkg::IRQ_STATUS_RST;
      irq_mask <= cmcm_pkg::IRQ_MASK_RST;
    end
    else if (ce)
    begin
      irq_status <= next_irq_status;
      if (wr_irq_mask)
      begin
        irq_mask <= bus_req.wdata[cmcm_pkg::IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read values; reserved bits are never driven, so they read zero
  logic [63:0] cache_ctl_word;
  logic [63:0] mc_status_word;
  logic [63:0] irq_status_word;
  logic [63:0] irq_mask_word;
  logic [63:0] own_word;
  logic own_hit;

  always_comb
  begin
    cache_ctl_word = cmcm_pkg::WORD_ZERO;
    cache_ctl_word[cmcm_pkg::CC_HW_EN_BIT] =
      second_level_cache_hw_enabled;
    cache_ctl_word[cmcm_pkg::CC_INIT_BIT] = cache_init;
    cache_ctl_word[cmcm_pkg::CC_ABSENT_BIT] =
      second_level_cache_absent;
  end

  always_comb
  begin
    mc_status_word = cmcm_pkg::WORD_ZERO;
    mc_status_word[cmcm_pkg::MC_RESTART_BIT] =
      restart_pointer_valid;
    mc_status_word[cmcm_pkg::MC_ERRPTR_BIT] = error_pointer_valid;
    mc_status_word[cmcm_pkg::MC_INPROG_BIT] =
      machine_check_in_progress;
  end

  assign irq_status_word = {{(64 - cmcm_pkg::IRQ_W){1'b0}}, irq_status};
  assign irq_mask_word = {{(64 - cmcm_pkg::IRQ_W){1'b0}}, irq_mask};

  assign own_hit = hit_cache_ctl || hit_mc_status || hit_mc_cap
                || hit_perf_status || hit_irq_status || hit_irq_mask;

  assign own_word =
    hit_cache_ctl ? cache_ctl_word :
    hit_mc_status ? mc_status_word :
    hit_mc_cap ? MC_CAP_VALUE :
    hit_perf_status ? performance_state_status :
    hit_irq_status ? irq_status_word :
    hit_irq_mask ? irq_mask_word :
    cmcm_pkg::WORD_ZERO;

  // Read data stand only in the cycle after the strobe; unmapped reads zero
  logic [63:0] own_rd_data;
  logic rd_from_slot;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      own_rd_data <= cmcm_pkg::WORD_ZERO;
      rd_from_slot <= 1'h0;
    end
    else if (ce)
    begin
      own_rd_data <= (bus_req.rd && own_hit) ? own_word
                                             : cmcm_pkg::WORD_ZERO;
      rd_from_slot <= bus_req.rd && hit_slot;
    end
  end

  assign rd_data = rd_from_slot ? slot_rd_data : own_rd_data;

endmodule

//--- tb/cmcm_top_asserts.sv
// Assertion checker for the cache and machine-check slice
`timescale 1ns/1ps
module cmcm_top_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire cmcm_pkg::cmcm_bus_req_t bus_req,
  input wire logic [63:0] rd_data,
  input wire logic second_level_cache_hw_enabled,
  input wire logic second_level_cache_absent,
  input wire logic writeback_invalidate_request,
  input wire cmcm_pkg::cmcm_mc_event_t mc_event,
  input wire logic cache_flush_start,
  input wire logic machine_check_exception,
  input wire logic shutdown
);
  logic init_q;
  logic busy_q;
  wire wr_on = ce && bus_req.wr;
  wire cc_hit = bus_req.addr == cmcm_pkg::OFF_CACHE_CTL;
  wire mc_hit = bus_req.addr == cmcm_pkg::OFF_MC_STATUS;
  wire cc_rd = ce && bus_req.rd && cc_hit;
  wire mc_rd = ce && bus_req.rd && mc_hit;
  wire hit = ce && mc_event.detect;
  wire deliver = hit && !busy_q;
  // Shadow copies rebuilt from bus traffic, machine-check detects and shutdown, since the bodies are hidden
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      init_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      if (wr_on && cc_hit)
        init_q <= bus_req.wdata[8];
      // Detect beats a same-cycle write; shutdown freezes the bit
      if (!shutdown && hit)
        busy_q <= 1'b1;
      else if (!shutdown && wr_on && mc_hit)
        busy_q <= bus_req.wdata[2];
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_hw_en_bit: assert property (
    cc_rd |=> rd_data[0] == $past(second_level_cache_hw_enabled))
    else $error("hardware enable bit wrong");
  chk_absent_bit: assert property (
    cc_rd |=> rd_data[23] == $past(second_level_cache_absent))
    else $error("absent bit wrong");
  chk_init_bit: assert property (
    cc_rd |=> rd_data[8] == $past(init_q))
    else $error("init bit wrong");
  chk_cache_rsvd: assert property (
    cc_rd |=> rd_data[63:24] == 40'h0 && rd_data[22:9] == 14'h0
      && rd_data[7:1] == 7'h0)
    else $error("cache reserved bits set");
  chk_status_read: assert property (
    mc_rd |=> rd_data[63:3] == 61'h0 && rd_data[2] == $past(busy_q))
    else $error("status word wrong");
  chk_flush_gate: assert property (
    cache_flush_start |-> $past(init_q))
    else $error("flush while uninitialised");
  chk_flush_take: assert property (
    ce && writeback_invalidate_request && init_q |=> cache_flush_start)
    else $error("flush request lost");
  chk_mc_deliver: assert property (
    deliver |=> machine_check_exception && !shutdown)
    else $error("exception not delivered");
  chk_exc_cause: assert property (
    machine_check_exception |-> $past(deliver))
    else $error("exception without cause");
  chk_mc_shutdown: assert property (
    hit && busy_q |=> shutdown && !machine_check_exception)
    else $error("second check did not shut down");
  chk_shutdown_held: assert property (shutdown |=> shutdown)
    else $error("shutdown dropped");
endmodule

//--- tb/tb.sv
// Self-checking bench for the cache and machine-check slice
`timescale 1ns/1ps
module tb;
  localparam logic [63:0] CAP = 64'h0a05;
  typedef struct packed {
    logic [11:0] a;
    logic [63:0] w;
    logic [63:0] e;
  } cmcm_row_t;
  logic clk;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic hw = 1'b1;
  logic gone = 1'b0;
  logic flush_n = 1'b1;
  logic wbinv = 1'b0;
  logic [63:0] pstat = 64'h0123_4567_89ab_cdef;
  cmcm_pkg::cmcm_bus_req_t req = '0;
  cmcm_pkg::cmcm_mc_event_t mce = '0;
  logic [63:0] rd_data;
  logic flush_go;
  logic mc_exc;
  logic sd;
  logic irq;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  cmcm_row_t rows [13];

  cmcm_top #(.MC_CAP_VALUE(CAP)) u_cmcm_top (
    .clk, .arst_n, .ce, .bus_req(req), .rd_data,
    .second_level_cache_hw_enabled(hw), .second_level_cache_absent(gone),
    .flush_n, .writeback_invalidate_request(wbinv), .mc_event(mce),
    .performance_state_status(pstat), .cache_flush_start(flush_go),
    .machine_check_exception(mc_exc), .shutdown(sd), .irq);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [11:0] a, input logic [63:0] e);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, 64'h0};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 check(rd_data, e);
  endtask

  task automatic watch(output int k);
    k = 0;
    repeat (6)
    begin
      #1 if (flush_go === 1'b1) k++;
      @(posedge clk);
    end
  endtask

  // Pin path needs sync cycles, so both kinds share a six-cycle watch
  task automatic fl(input logic pin, output int k);
    @(posedge clk);
    if (pin)
      flush_n <= 1'b0;
    else
      wbinv <= 1'b1;
    @(posedge clk);
    flush_n <= 1'b1;
    wbinv <= 1'b0;
    watch(k);
  endtask

  task automatic mc(input logic ro, input logic ea);
    @(posedge clk);
    mce <= '{1'b1, ro, ea};
    @(posedge clk);
    mce.detect <= 1'b0;
    #1;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      finish_test;
    end
  end

  initial
  begin
    rows = '{'{cmcm_pkg::OFF_CACHE_CTL, '1, 64'h101},
      '{cmcm_pkg::OFF_MC_STATUS, 64'hffff_ffff_ffff_fffb, 64'h3},
      '{cmcm_pkg::OFF_MC_CAP, '1, CAP},
      '{cmcm_pkg::OFF_PERF_STATUS, '1, pstat},
      '{12'h3ff, '1, 64'h0},
      '{cmcm_pkg::OFF_IRQ_MASK, 64'h5, 64'h5},
      '{cmcm_pkg::OFF_FAST_CS, 64'h8000_0000_0000_0011, 64'h8000_0000_0000_0011},
      '{cmcm_pkg::OFF_FAST_SP, 64'h4000_0000_0000_0022, 64'h4000_0000_0000_0022},
      '{cmcm_pkg::OFF_FAST_IP, 64'h2000_0000_0000_0033, 64'h2000_0000_0000_0033},
      '{cmcm_pkg::OFF_PERF_SEL0, 64'h1000_0000_0000_0044, 64'h1000_0000_0000_0044},
      '{cmcm_pkg::OFF_PERF_SEL1, 64'h0800_0000_0000_0055, 64'h0800_0000_0000_0055},
      '{cmcm_pkg::OFF_PERF_CTL, 64'h0400_0000_0000_0066, 64'h0400_0000_0000_0066},
      '{cmcm_pkg::OFF_CLK_MOD, 64'h0200_0000_0000_0077, 64'h0200_0000_0000_0077}};
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rc(rows[i].a, rows[i].e);
    end
    $display("register rows done");
    @(posedge clk);
    hw <= 1'b0;
    gone <= 1'b1;
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    rc(cmcm_pkg::OFF_CACHE_CTL, 64'h80_0000);
    fl(1'b0, n);
    check(64'(n), 64'h0);
    fl(1'b1, n);
    check(64'(n), 64'h0);
    check(64'(irq), 64'h0);
    rc(cmcm_pkg::OFF_IRQ_STATUS, 64'h8);
    wr(cmcm_pkg::OFF_IRQ_MASK, 64'hf);
    #1 check(64'(irq), 64'h1);
    wr(cmcm_pkg::OFF_IRQ_STATUS, 64'hf);
    #1 check(64'(irq), 64'h0);
    wr(cmcm_pkg::OFF_CACHE_CTL, 64'h100);
    fl(1'b0, n);
    check(64'(n), 64'h1);
    fl(1'b1, n);
    check(64'(n), 64'h1);
    // Clock enable low: a request in that time is lost, nothing moves
    @(posedge clk);
    ce <= 1'b0;
    fl(1'b0, n);
    ce <= 1'b1;
    check(64'(n), 64'h0);
    rc(cmcm_pkg::OFF_IRQ_STATUS, 64'h4);
    wr(cmcm_pkg::OFF_IRQ_STATUS, 64'hf);
    $display("flush tests done");
    mc(1'b1, 1'b0);
    check(64'({sd, mc_exc}), 64'h1);
    rc(cmcm_pkg::OFF_MC_STATUS, 64'h5);
    wr(cmcm_pkg::OFF_MC_STATUS, 64'h0);
    rc(cmcm_pkg::OFF_MC_STATUS, 64'h0);
    mc(1'b0, 1'b1);
    check(64'({sd, mc_exc}), 64'h1);
    rc(cmcm_pkg::OFF_MC_STATUS, 64'h6);
    mc(1'b1, 1'b1);
    check(64'({sd, mc_exc}), 64'h2);
    wr(cmcm_pkg::OFF_MC_STATUS, 64'h0);
    rc(cmcm_pkg::OFF_MC_STATUS, 64'h6);
    rc(cmcm_pkg::OFF_IRQ_STATUS, 64'h3);
    check(64'(irq), 64'h1);
    $display("machine check tests done");
    finish_test;
  end
endmodule

bind cmcm_top cmcm_top_asserts u_cmcm_top_asserts (
  .clk, .arst_n, .ce, .bus_req, .rd_data,
  .second_level_cache_hw_enabled, .second_level_cache_absent,
  .writeback_invalidate_request, .mc_event, .cache_flush_start,
  .machine_check_exception, .shutdown);
